// ==== rtl/gauge_defs.svh ====
// constants for the gauge session sequencer
`ifndef GAUGE_DEFS_SVH
`define GAUGE_DEFS_SVH

`define REG_ADDR_W 8
`define ADDR_OPCFG 8'h00
`define ADDR_SUBCMD 8'h04
`define ADDR_REPORT 8'h08
`define ADDR_PASSED 8'h0c
`define ADDR_HEALTH 8'h10
`define ADDR_CALV 8'h14
`define ADDR_LIFETIME 8'h18

`define OPCFG_POWER 0
`define OPCFG_MODE_LO 1
`define OPCFG_MODE_HI 2
`define OPCFG_DIVIDER 3
`define OPCFG_CAL_EN 4

`define MODE_ACCUM 2'h0
`define MODE_HEALTH 2'h1
`define MODE_SERVICE_END 2'h2

`define CMD_BEGIN 16'h0011
`define CMD_END 16'h0012
`define CMD_RESET 16'h0041

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`define CLK_PERIOD_NS 10
`define INIT_TIME_NS 2000
`define FINISH_TIME_NS 500
`define INIT_CYCLES \
  ((`INIT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FINISH_CYCLES \
  ((`FINISH_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== rtl/gauge_pkg.sv ====
// types shared by the gauge session sequencer
package gauge_pkg;
`include "gauge_defs.svh"

  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_INIT = 3'b001,
    ST_IDLE = 3'b010,
    ST_GAUGING = 3'b011,
    ST_FINISH = 3'b100
  } seq_state_e;

  typedef struct packed {
    logic power;
    logic power_prev;
    logic [1:0] mode;
    logic divider;
    logic cal_en;
    seq_state_e state;
    logic [15:0] timer;
    logic init_flag;
    logic done_flag;
    logic eos_warn;
    logic health_low;
    logic alert;
    logic [7:0] lifetime;
    logic [15:0] last_cmd;
    logic aw_held;
    logic [`REG_ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } seq_s;
endpackage

// ==== rtl/charge_accumulator.sv ====
// discharge accumulator for the passed charge total
`timescale 1ns/1ps
`include "gauge_defs.svh"
module charge_accumulator #(
  parameter int SAMPLE_W = 16,
  parameter int TOTAL_W = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clear,
  input wire logic enable,
  input wire logic sample_valid,
  input wire logic [SAMPLE_W-1:0] sample,
  output logic [TOTAL_W-1:0] total
);
  logic [TOTAL_W-1:0] total_reg;
  logic [TOTAL_W-1:0] total_next;

  always_comb begin
    total_next = total_reg;
    if (clear) begin
      total_next = '0;
    end else if (enable && sample_valid) begin
      // wraps silently; width is a parameter for long sessions
      total_next = total_reg + TOTAL_W'(sample);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      total_reg <= '0;
    end else begin
      total_reg <= total_next;
    end
  end

  assign total = total_reg;

  a_clear_zeroes_total: assert property (
    @(posedge aclk) disable iff (!aresetn) clear |=> total == '0)
    else $error("total not zero after clear");

  a_idle_total_holds: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (!clear && !(enable && sample_valid)) |=> $stable(total))
    else $error("total moved while not accumulating");
endmodule

// ==== rtl/subcmd_decoder.sv ====
// decodes two-byte control subcommand codes
`timescale 1ns/1ps
`include "gauge_defs.svh"
module subcmd_decoder (
  input wire logic [15:0] code,
  output logic is_begin,
  output logic is_end,
  output logic is_reset
);
  function automatic logic code_is(input logic [15:0] c,
                                   input logic [15:0] ref_code);
    code_is = (c == ref_code);
  endfunction

  always_comb begin
    is_begin = code_is(code, `CMD_BEGIN);
    is_end = code_is(code, `CMD_END);
    is_reset = code_is(code, `CMD_RESET);
  end
endmodule

// ==== rtl/gauge_session_sequencer.sv ====
// gauging session sequencer with axi4-lite register slave
//
// Design decisions made here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "gauge_defs.svh"
module gauge_session_sequencer #(
  parameter logic [15:0] SERVICE_END_RES_LIMIT = 16'h0400,
  parameter logic [7:0] HEALTH_LOW_LIMIT = 8'h14
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`REG_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`REG_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic discharge_valid,
  input wire logic [15:0] discharge_amount,
  input wire logic [15:0] cell_millivolts,
  input wire logic [15:0] cell_counts,
  input wire logic [7:0] health_estimate,
  input wire logic [15:0] cell_resistance,
  output logic host_alert_out,
  output logic host_alert_oe_n,
  output logic measure_enable,
  output logic external_divider_select,
  output logic cal_active
);
  gauge_pkg::seq_s r;
  gauge_pkg::seq_s n;

  logic aw_fire;
  logic w_fire;
  logic ar_fire;
  logic wr_go;
  logic [`REG_ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic cmd_go;
  logic cmd_begin;
  logic cmd_end;
  logic cmd_reset;
  logic acc_clear;
  logic acc_enable;
  logic [31:0] passed_charge_total;
  logic [7:0] health_percent_reading;
  logic [15:0] cal_reading;
  logic [31:0] cell_condition_report;

  function automatic logic is_mode(input logic [1:0] m,
                                   input logic [1:0] code);
    is_mode = (m == code);
  endfunction

  assign s_axi_awready = !r.aw_held && !r.bvalid;
  assign s_axi_wready = !r.w_held && !r.bvalid;
  assign s_axi_arready = !r.rvalid;
  assign aw_fire = s_axi_awvalid && s_axi_awready;
  assign w_fire = s_axi_wvalid && s_axi_wready;
  assign ar_fire = s_axi_arvalid && s_axi_arready;

  // address and data may arrive in either order
  assign wr_go = (r.aw_held || aw_fire) && (r.w_held || w_fire);
  assign wr_addr = r.aw_held ? r.aw_addr : s_axi_awaddr;
  assign wr_data = r.w_held ? r.w_data : s_axi_wdata;
  assign wr_strb = r.w_held ? r.w_strb : s_axi_wstrb;

  // both code bytes must be written for a command to count
  assign cmd_go = wr_go && wr_addr == `ADDR_SUBCMD &&
                  wr_strb[1:0] == 2'h3;

  subcmd_decoder u_decoder (
    .code(wr_data[15:0]),
    .is_begin(cmd_begin),
    .is_end(cmd_end),
    .is_reset(cmd_reset)
  );

  assign acc_clear = (r.state == gauge_pkg::ST_OFF) ||
                     (r.state == gauge_pkg::ST_INIT) ||
                     (cmd_go && cmd_begin &&
                      r.state == gauge_pkg::ST_IDLE);
  assign acc_enable = (r.state == gauge_pkg::ST_GAUGING);

  charge_accumulator #(
    .SAMPLE_W(16),
    .TOTAL_W(32)
  ) u_accum (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(acc_clear),
    .enable(acc_enable),
    .sample_valid(discharge_valid),
    .sample(discharge_amount),
    .total(passed_charge_total)
  );

  // accumulator mode has no health result
  assign health_percent_reading = is_mode(r.mode, `MODE_ACCUM) ?
                                  8'h00 : health_estimate;
  assign cal_reading = r.divider ? cell_counts : cell_millivolts;
  assign cell_condition_report = {24'h000000, r.state,
                                  r.state == gauge_pkg::ST_GAUGING,
                                  r.health_low, r.eos_warn,
                                  r.done_flag, r.init_flag};

  always_comb begin
    n = r;
    n.power_prev = r.power;
    // bus write side
    if (aw_fire) begin
      n.aw_held = 1'b1;
      n.aw_addr = s_axi_awaddr;
    end
    if (w_fire) begin
      n.w_held = 1'b1;
      n.w_data = s_axi_wdata;
      n.w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (wr_go) begin
      n.aw_held = 1'b0;
      n.w_held = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = `RESP_OKAY;
      case (wr_addr)
        `ADDR_OPCFG: begin
          if (wr_strb[0]) begin
            n.power = wr_data[`OPCFG_POWER];
            n.mode = wr_data[`OPCFG_MODE_HI:`OPCFG_MODE_LO];
            n.divider = wr_data[`OPCFG_DIVIDER];
            n.cal_en = wr_data[`OPCFG_CAL_EN];
          end
        end
        `ADDR_SUBCMD: begin
          if (wr_strb[1:0] == 2'h3) begin
            n.last_cmd = wr_data[15:0];
          end
        end
        default: begin
          n.bresp = `RESP_SLVERR;
        end
      endcase
    end
    // bus read side
    if (s_axi_rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (ar_fire) begin
      n.rvalid = 1'b1;
      n.rresp = `RESP_OKAY;
      case (s_axi_araddr)
        `ADDR_OPCFG: n.rdata = {27'h0000000, r.cal_en, r.divider,
                                r.mode, r.power};
        `ADDR_SUBCMD: n.rdata = {16'h0000, r.last_cmd};
        `ADDR_REPORT: begin
          n.rdata = cell_condition_report;
          // the report read releases the alert; later sets win
          n.alert = 1'b0;
        end
        `ADDR_PASSED: n.rdata = passed_charge_total;
        `ADDR_HEALTH: n.rdata = {24'h000000, health_percent_reading};
        `ADDR_CALV: n.rdata = {16'h0000, cal_reading};
        `ADDR_LIFETIME: n.rdata = {24'h000000, r.lifetime};
        default: begin
          n.rdata = 32'h00000000;
          n.rresp = `RESP_SLVERR;
        end
      endcase
    end
    // session sequencing
    if (!r.power) begin
      // unpowered: the configuration word, last_cmd and lifetime survive
      n.state = gauge_pkg::ST_OFF;
      n.timer = 16'h0000;
      n.init_flag = 1'b0;
      n.done_flag = 1'b0;
      n.eos_warn = 1'b0;
      n.health_low = 1'b0;
      n.alert = 1'b0;
    end else if (!r.power_prev || (cmd_go && cmd_reset)) begin
      n.state = gauge_pkg::ST_INIT;
      n.timer = 16'(`INIT_CYCLES);
      n.init_flag = 1'b0;
      n.done_flag = 1'b0;
      n.eos_warn = 1'b0;
      n.health_low = 1'b0;
      n.alert = 1'b0;
    end else begin
      case (r.state)
        gauge_pkg::ST_INIT: begin
          n.timer = r.timer - 16'h0001;
          if (r.timer == 16'h0001) begin
            n.init_flag = 1'b1;
            n.alert = 1'b1;
            n.state = gauge_pkg::ST_IDLE;
          end
        end
        gauge_pkg::ST_IDLE: begin
          if (cmd_go && cmd_begin) begin
            n.state = gauge_pkg::ST_GAUGING;
            n.done_flag = 1'b0;
          end else if (cmd_go && cmd_end &&
                       is_mode(r.mode, `MODE_HEALTH)) begin
            // health mode may end without a begin
            n.state = gauge_pkg::ST_FINISH;
            n.timer = 16'(`FINISH_CYCLES);
          end
        end
        gauge_pkg::ST_GAUGING: begin
          if (cmd_go && cmd_end) begin
            n.state = gauge_pkg::ST_FINISH;
            n.timer = 16'(`FINISH_CYCLES);
          end
        end
        gauge_pkg::ST_FINISH: begin
          n.timer = r.timer - 16'h0001;
          if (r.timer == 16'h0001) begin
            n.state = gauge_pkg::ST_IDLE;
            n.done_flag = 1'b1;
            n.alert = 1'b1;
            if (is_mode(r.mode, `MODE_SERVICE_END)) begin
              n.eos_warn = cell_resistance > SERVICE_END_RES_LIMIT;
            end
            if (is_mode(r.mode, `MODE_HEALTH)) begin
              n.lifetime = r.lifetime + 8'h01;
              n.health_low = health_estimate < HEALTH_LOW_LIMIT;
            end
          end
        end
        default: begin
          n.state = gauge_pkg::ST_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0; // mode 0 selects the accumulator by default
    end else begin
      r <= n;
    end
  end

  // open-drain alert: driven low while pending; the pending flag clears one cycle after power drops
  assign host_alert_out = 1'b0;
  assign host_alert_oe_n = !r.alert;
  assign measure_enable = (r.state != gauge_pkg::ST_OFF);
  assign external_divider_select = r.divider;
  assign cal_active = r.cal_en && (r.state != gauge_pkg::ST_OFF) &&
                      is_mode(r.mode, `MODE_ACCUM);
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rresp = r.rresp;
  assign s_axi_rdata = r.rdata;

  a_off_undriven: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !r.power |=> (r.state == gauge_pkg::ST_OFF) && host_alert_oe_n &&
                 !measure_enable)
    else $error("device active or alert driven while unpowered");

  a_init_then_alert: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $rose(r.init_flag) |-> !host_alert_oe_n &&
                           $past(r.state) == gauge_pkg::ST_INIT)
    else $error("init complete without alert low");

  a_power_rise_init: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (r.power && !r.power_prev) |=> r.state == gauge_pkg::ST_INIT &&
                                   !r.init_flag)
    else $error("power rise did not restart initialisation");

  a_report_releases: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ar_fire && s_axi_araddr == `ADDR_REPORT &&
     r.state == gauge_pkg::ST_IDLE && !cmd_go)
    |=> host_alert_oe_n)
    else $error("report read did not release alert");

  a_done_alert: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $rose(r.done_flag) |-> !host_alert_oe_n &&
                           $past(r.state) == gauge_pkg::ST_FINISH)
    else $error("done flag without alert low");

  a_cal_accum_only: assert property (
    @(posedge aclk) disable iff (!aresetn)
    cal_active |-> r.mode == `MODE_ACCUM)
    else $error("calibration outside accumulator mode");

  a_accum_no_health: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ar_fire && s_axi_araddr == `ADDR_HEALTH && r.mode == `MODE_ACCUM)
    |=> s_axi_rdata == 32'h00000000)
    else $error("health result reported in accumulator mode");

  a_begin_gauging: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (cmd_go && cmd_begin && r.power && r.power_prev &&
     r.state == gauge_pkg::ST_IDLE)
    |=> r.state == gauge_pkg::ST_GAUGING)
    else $error("begin code did not start gauging");

  a_end_finish: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (cmd_go && cmd_end && r.power && r.power_prev &&
     r.state == gauge_pkg::ST_GAUGING)
    |=> r.state == gauge_pkg::ST_FINISH ##[1:60] r.done_flag)
    else $error("end code did not finish gauging in time");

  a_divider_counts: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ar_fire && s_axi_araddr == `ADDR_CALV && r.divider)
    |=> s_axi_rdata[15:0] == $past(cell_counts))
    else $error("divider mode did not report raw counts");
endmodule

// ==== verif/host_model.sv ====
// host side model: axi4-lite master used by the bench
`timescale 1ns/1ps
module host_model (
  input wire logic aclk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  initial begin
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
  end

  // ready seen at the falling edge holds until the next rising edge,
  // so the handshake edge is known without racing the slave
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    logic b_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    b_ok = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_ok) begin
      @(negedge aclk);
      if (awvalid && awready) aw_ok = 1'b1;
      if (wvalid && wready) w_ok = 1'b1;
      if (bvalid) begin
        b_ok = 1'b1;
        r = bresp;
      end
      @(posedge aclk);
      // released awaddr and wdata show a changed value, never the stale one; wstrb keeps its old value
      if (aw_ok && awvalid) begin
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (w_ok && wvalid) begin
        wvalid <= 1'b0;
        wdata <= ~d;
      end
      if (b_ok) bready <= 1'b0;
    end
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    logic ar_ok;
    logic r_ok;
    ar_ok = 1'b0;
    r_ok = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_ok) begin
      @(negedge aclk);
      if (arvalid && arready) ar_ok = 1'b1;
      if (rvalid) begin
        r_ok = 1'b1;
        d = rdata;
        r = rresp;
      end
      @(posedge aclk);
      if (ar_ok && arvalid) begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
      if (r_ok) rready <= 1'b0;
    end
  endtask
endmodule

// ==== verif/gauge_session_sequencer_bench.sv ====
// self-checking bench for the gauge session sequencer
`timescale 1ns/1ps
`include "gauge_defs.svh"
module gauge_session_sequencer_bench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic discharge_valid = 1'b0;
  logic [15:0] discharge_amount = 16'h0005;
  logic [15:0] cell_millivolts = 16'h0e10;
  logic [15:0] cell_counts = 16'h5a3c;
  logic [7:0] health_estimate = 8'h0a;
  logic [15:0] cell_resistance = 16'h0500;
  logic alert_o, alert_oe_n, meas_en, div_sel, cal_act;
  int miscompares = 0;
  int cmp_count = 0;

  always #5 aclk = ~aclk;

  host_model u_host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready));

  gauge_session_sequencer u_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .discharge_valid(discharge_valid),
    .discharge_amount(discharge_amount),
    .cell_millivolts(cell_millivolts), .cell_counts(cell_counts),
    .health_estimate(health_estimate), .cell_resistance(cell_resistance),
    .host_alert_out(alert_o), .host_alert_oe_n(alert_oe_n),
    .measure_enable(meas_en), .external_divider_select(div_sel),
    .cal_active(cal_act));

  task automatic close_out;
    if (miscompares == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk32(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk1(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic [1:0] r;
    u_host.axi_write(a, d, r);
    chk32("bresp", {30'h0, er}, {30'h0, r});
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                        input string nm);
    logic [31:0] d;
    logic [1:0] r;
    u_host.axi_read(a, d, r);
    chk32(nm, e, d);
    chk32("rresp", {30'h0, `RESP_OKAY}, {30'h0, r});
  endtask

  // the host polls alert_oe_n for up to 400 falling edges, then checks that it is low
  task automatic wait_alert;
    int n;
    for (n = 0; n < 400 && alert_oe_n !== 1'b0; n++) @(negedge aclk);
    chk1("alert_oe_n low", 1'b0, alert_oe_n);
  endtask

  task automatic pulse(input int n);
    @(posedge aclk);
    discharge_valid <= 1'b1;
    repeat (n) @(posedge aclk);
    discharge_valid <= 1'b0;
  endtask

  task automatic power_up(input logic [31:0] cfg);
    wr(`ADDR_OPCFG, cfg, `RESP_OKAY);
    wait_alert();
    chk1("alert data", 1'b0, alert_o);
    chk1("measure on", 1'b1, meas_en);
    rd_chk(`ADDR_REPORT, 32'h41, "report init");
    @(negedge aclk);
    chk1("alert released", 1'b1, alert_oe_n);
  endtask

  task automatic t_reset_state;
    chk1("alert_oe_n off", 1'b1, alert_oe_n);
    chk1("alert data off", 1'b0, alert_o);
    chk1("measure off", 1'b0, meas_en);
    rd_chk(`ADDR_OPCFG, 32'h0, "opcfg reset");
  endtask

  task automatic t_accumulate;
    power_up(32'h11);
    chk1("cal active", 1'b1, cal_act);
    chk1("divider off", 1'b0, div_sel);
    rd_chk(`ADDR_CALV, 32'h0e10, "calv mv");
    wr(`ADDR_SUBCMD, {16'h0, `CMD_BEGIN}, `RESP_OKAY);
    repeat (3) @(posedge aclk);
    pulse(10);
    repeat (3) @(posedge aclk);
    rd_chk(`ADDR_PASSED, 32'd50, "passed mid");
    rd_chk(`ADDR_REPORT, 32'h71, "report gauging");
    rd_chk(`ADDR_HEALTH, 32'h0, "health acc");
    pulse(4);
    repeat (3) @(posedge aclk);
    wr(`ADDR_SUBCMD, {16'h0, `CMD_END}, `RESP_OKAY);
    wait_alert();
    rd_chk(`ADDR_REPORT, 32'h43, "report done");
    rd_chk(`ADDR_PASSED, 32'd70, "passed final");
    wr(`ADDR_OPCFG, 32'h10, `RESP_OKAY);
    repeat (2) @(negedge aclk);
    chk1("measure off", 1'b0, meas_en);
    chk1("alert undriven", 1'b1, alert_oe_n);
    chk1("cal off", 1'b0, cal_act);
    rd_chk(`ADDR_OPCFG, 32'h10, "config kept");
    rd_chk(`ADDR_PASSED, 32'h0, "passed cleared");
  endtask

  task automatic t_health;
    power_up(32'h13);
    chk1("cal in health", 1'b0, cal_act);
    wr(`ADDR_SUBCMD, {16'h0, `CMD_RESET}, `RESP_OKAY);
    wait_alert();
    rd_chk(`ADDR_REPORT, 32'h41, "report reinit");
    rd_chk(`ADDR_HEALTH, 32'h0a, "health");
    wr(`ADDR_SUBCMD, {16'h0, `CMD_END}, `RESP_OKAY);
    wait_alert();
    rd_chk(`ADDR_REPORT, 32'h4b, "report health");
    rd_chk(`ADDR_LIFETIME, 32'h1, "lifetime");
    // healthy estimate: a second end must clear the low flag
    health_estimate <= 8'h50;
    wr(`ADDR_SUBCMD, {16'h0, `CMD_END}, `RESP_OKAY);
    wait_alert();
    rd_chk(`ADDR_REPORT, 32'h43, "report health ok");
    rd_chk(`ADDR_LIFETIME, 32'h2, "lifetime again");
    health_estimate <= 8'h0a;
    wr(`ADDR_OPCFG, 32'h02, `RESP_OKAY);
  endtask

  task automatic t_service_end;
    power_up(32'h0d);
    chk1("divider", 1'b1, div_sel);
    rd_chk(`ADDR_CALV, 32'h5a3c, "calv counts");
    wr(`ADDR_SUBCMD, {16'h0, `CMD_BEGIN}, `RESP_OKAY);
    // lead time before the load pulse is shortened for run length
    repeat (20) @(posedge aclk);
    pulse(8);
    wr(`ADDR_SUBCMD, {16'h0, `CMD_END}, `RESP_OKAY);
    wait_alert();
    rd_chk(`ADDR_REPORT, 32'h47, "report eos");
    rd_chk(`ADDR_HEALTH, 32'h0a, "health eos");
    // low resistance: the next session must post no warning
    cell_resistance <= 16'h0300;
    wr(`ADDR_SUBCMD, {16'h0, `CMD_BEGIN}, `RESP_OKAY);
    repeat (20) @(posedge aclk);
    pulse(8);
    wr(`ADDR_SUBCMD, {16'h0, `CMD_END}, `RESP_OKAY);
    wait_alert();
    rd_chk(`ADDR_REPORT, 32'h43, "report no eos");
    wr(`ADDR_OPCFG, 32'h0c, `RESP_OKAY);
  endtask

  task automatic t_bus_errors;
    logic [31:0] d;
    logic [1:0] r;
    wr(`ADDR_REPORT, 32'hff, `RESP_SLVERR);
    u_host.axi_read(8'h1c, d, r);
    chk32("unmapped resp", {30'h0, `RESP_SLVERR}, {30'h0, r});
    chk32("unmapped data", 32'h0, d);
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    close_out();
  end

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    t_reset_state();
    t_accumulate();
    t_health();
    t_service_end();
    t_bus_errors();
    close_out();
  end
endmodule
